// File: design/apsrc_pkg.sv
package apsrc_pkg;

    // Register byte addresses
    localparam logic [31:0] ADDR_MODE_CTRL = 32'hffffcd5c;
    localparam logic [31:0] ADDR_RES_EN = 32'hffffcd60;
    localparam logic [31:0] ADDR_IRQ_STAT = 32'hffffcd70;
    localparam logic [31:0] ADDR_IRQ_MASK = 32'hffffcd74;
    localparam logic [31:0] ADDR_RESULT_BASE = 32'hffffcd80;

    // Field positions
    localparam int MODE_DONE_BIT = 7;
    localparam int MODE_EN_BIT = 0;
    localparam int RES_FRESH_BIT = 15;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ABORT_BIT = 1;
    localparam int IRQ_OVERRUN_BIT = 2;

    // Sizes
    localparam int NUM_RESULTS = 8;
    localparam int CHAN_W = 3;
    localparam int CONV_DATA_W = 10;
    localparam int NUM_EVENTS = 3;

    // Reset values
    localparam logic [15:0] RES_EN_RESET = 16'h0000;
    localparam logic MODE_EN_RESET = 1'b0;
    localparam logic MODE_DONE_RESET = 1'b0;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    typedef struct packed {
        logic [7:0] upper;
        logic [7:0] en;
    } apsrc_res_en_t;

    typedef struct packed {
        logic overrun;
        logic abort;
        logic done;
    } apsrc_evt_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_START,
        ST_WAIT
    } apsrc_state_t;

endpackage

// File: design/apsrc_result_slot.sv
module apsrc_result_slot #(
    parameter int DATA_W = 10
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [DATA_W-1:0] din,
    input wire logic read_clr,
    output logic [DATA_W-1:0] data,
    output logic fresh
);
    logic [DATA_W-1:0] data_ff;
    logic [DATA_W-1:0] nxt_data;
    logic fresh_ff;
    logic nxt_fresh;

    always_comb begin
        nxt_data = data_ff;
        nxt_fresh = fresh_ff;
        if (read_clr) begin
            nxt_fresh = 1'b0;
        end
        // New result wins over a read clear in the same cycle
        if (load) begin
            nxt_data = din;
            nxt_fresh = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            data_ff <= '0;
            fresh_ff <= 1'b0;
        end else begin
            data_ff <= nxt_data;
            fresh_ff <= nxt_fresh;
        end
    end

    assign data = data_ff;
    assign fresh = fresh_ff;
endmodule // apsrc_result_slot

// File: design/apsrc_ctrl.sv
// Chosen here: strobed register access.
module apsrc_ctrl
    import apsrc_pkg::*;
#(
    parameter int DATA_W = CONV_DATA_W
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [31:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic TRIG,
    output logic CONV_START,
    output logic [CHAN_W-1:0] CONV_CHAN,
    input wire logic CONV_DONE,
    input wire logic [DATA_W-1:0] CONV_DATA,
    output logic IRQ
);
    // Lowest enabled index at or above a start point; bit 3 set means none
    function automatic logic [3:0] find_en(input logic [7:0] en, input logic [3:0] from);
        logic [3:0] r;
        r = 4'h8;
        for (int i = 7; i >= 0; i--) begin
            if (en[i] && (i >= int'(from))) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // Register bus decode
    logic sel_mode;
    logic sel_res_en;
    logic sel_stat;
    logic sel_mask;
    logic sel_result;
    logic [CHAN_W-1:0] result_idx;

    assign sel_mode = (ADDR == ADDR_MODE_CTRL);
    assign sel_res_en = (ADDR == ADDR_RES_EN);
    assign sel_stat = (ADDR == ADDR_IRQ_STAT);
    assign sel_mask = (ADDR == ADDR_IRQ_MASK);
    assign sel_result = (ADDR[31:5] == ADDR_RESULT_BASE[31:5]);
    assign result_idx = ADDR[4:2];

    // Software-written state
    apsrc_res_en_t res_en_ff;
    apsrc_res_en_t nxt_res_en;
    logic enable_ff;
    logic nxt_enable;
    logic [NUM_EVENTS-1:0] mask_ff;
    logic [NUM_EVENTS-1:0] nxt_mask;

    always_comb begin
        nxt_res_en = res_en_ff;
        nxt_enable = enable_ff;
        nxt_mask = mask_ff;
        if (WR && sel_res_en) begin
            // Upper byte stored as written; it steers nothing
            nxt_res_en = WDATA[15:0];
        end
        if (WR && sel_mode) begin
            nxt_enable = WDATA[MODE_EN_BIT];
        end
        if (WR && sel_mask) begin
            nxt_mask = WDATA[NUM_EVENTS-1:0];
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            res_en_ff <= RES_EN_RESET;
            enable_ff <= MODE_EN_RESET;
            mask_ff <= IRQ_RESET;
        end else begin
            res_en_ff <= nxt_res_en;
            enable_ff <= nxt_enable;
            mask_ff <= nxt_mask;
        end
    end

    // Sequencer
    apsrc_state_t state_ff;
    apsrc_state_t nxt_state;
    logic [CHAN_W-1:0] chan_ff;
    logic [CHAN_W-1:0] nxt_chan;
    logic done_ff;
    logic nxt_done;
    logic load;
    apsrc_evt_t evt;
    logic [3:0] first_en;
    logic [3:0] next_en;

    assign first_en = find_en(res_en_ff.en, 4'h0);
    assign next_en = find_en(res_en_ff.en, {1'b0, chan_ff} + 4'h1);

    always_comb begin
        nxt_state = state_ff;
        nxt_chan = chan_ff;
        nxt_done = done_ff;
        load = 1'b0;
        evt = '0;
        case (state_ff)
            ST_IDLE: begin
                if (TRIG && enable_ff && !first_en[3]) begin
                    nxt_done = 1'b1;
                    nxt_chan = first_en[CHAN_W-1:0];
                    nxt_state = ST_START;
                end
            end
            ST_START: begin
                nxt_state = ST_WAIT;
            end
            ST_WAIT: begin
                if (CONV_DONE) begin
                    load = 1'b1;
                    if (!enable_ff) begin
                        nxt_done = 1'b0;
                        evt.abort = 1'b1;
                        nxt_state = ST_IDLE;
                    end else if (next_en[3]) begin
                        nxt_done = 1'b0;
                        evt.done = 1'b1;
                        nxt_state = ST_IDLE;
                    end else begin
                        nxt_chan = next_en[CHAN_W-1:0];
                        nxt_state = ST_START;
                    end
                end
            end
            default: begin
                nxt_state = ST_IDLE;
                nxt_done = 1'b0;
            end
        endcase
        if (TRIG && (state_ff != ST_IDLE)) begin
            evt.overrun = 1'b1;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            state_ff <= ST_IDLE;
            chan_ff <= '0;
            done_ff <= MODE_DONE_RESET;
        end else begin
            state_ff <= nxt_state;
            chan_ff <= nxt_chan;
            done_ff <= nxt_done;
        end
    end

    assign CONV_START = (state_ff == ST_START);
    assign CONV_CHAN = chan_ff;

    // Result storage
    logic [DATA_W-1:0] slot_data [NUM_RESULTS];
    logic [NUM_RESULTS-1:0] slot_fresh;

    for (genvar g = 0; g < NUM_RESULTS; g++) begin : g_slot
        apsrc_result_slot #(
            .DATA_W(DATA_W)
        ) u_slot (
            .clk(CLK),
            .reset(RESET),
            .load(load && (chan_ff == CHAN_W'(g))),
            .din(CONV_DATA),
            .read_clr(RD && sel_result && (result_idx == CHAN_W'(g))),
            .data(slot_data[g]),
            .fresh(slot_fresh[g])
        );
    end

    // Interrupt status, write one to clear, set wins
    logic [NUM_EVENTS-1:0] stat_ff;
    logic [NUM_EVENTS-1:0] nxt_stat;
    logic [NUM_EVENTS-1:0] stat_clr;

    always_comb begin
        stat_clr = (WR && sel_stat) ? WDATA[NUM_EVENTS-1:0] : '0;
        nxt_stat = (stat_ff & ~stat_clr) | evt;
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            stat_ff <= IRQ_RESET;
        end else begin
            stat_ff <= nxt_stat;
        end
    end

    assign IRQ = |(stat_ff & mask_ff);

    // Read data, valid only in the cycle after the strobe
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    always_comb begin
        nxt_rdata = '0;
        if (RD) begin
            if (sel_mode) begin
                nxt_rdata[MODE_DONE_BIT] = done_ff;
                nxt_rdata[MODE_EN_BIT] = enable_ff;
            end else if (sel_res_en) begin
                nxt_rdata[15:0] = res_en_ff;
            end else if (sel_stat) begin
                nxt_rdata[NUM_EVENTS-1:0] = stat_ff;
            end else if (sel_mask) begin
                nxt_rdata[NUM_EVENTS-1:0] = mask_ff;
            end else if (sel_result) begin
                nxt_rdata[DATA_W-1:0] = slot_data[result_idx];
                nxt_rdata[RES_FRESH_BIT] = slot_fresh[result_idx];
            end
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign RDATA = rdata_ff;

    // Checks
    a_start_sets_flag: assert property (@(posedge CLK) disable iff (RESET)
        (state_ff == ST_IDLE) && TRIG && enable_ff && (res_en_ff.en != 8'h00)
        |=> done_ff && (state_ff == ST_START))
        else $error("sequence start did not raise the done flag");

    a_flag_clears_last: assert property (@(posedge CLK) disable iff (RESET)
        (state_ff == ST_WAIT) && CONV_DONE && enable_ff && next_en[3]
        |=> !done_ff && (state_ff == ST_IDLE) && stat_ff[IRQ_DONE_BIT])
        else $error("done flag not cleared after last conversion");

    a_flag_held_busy: assert property (@(posedge CLK) disable iff (RESET)
        done_ff == (state_ff != ST_IDLE))
        else $error("done flag does not follow sequence activity");

    a_stop_on_disable: assert property (@(posedge CLK) disable iff (RESET)
        (state_ff == ST_WAIT) && CONV_DONE && !enable_ff
        |=> (state_ff == ST_IDLE) && !done_ff ##1 !CONV_START)
        else $error("sequence did not stop after enable cleared");

    a_result_stored: assert property (@(posedge CLK) disable iff (RESET)
        (state_ff == ST_WAIT) && CONV_DONE
        |=> (slot_data[$past(chan_ff)] == $past(CONV_DATA)) && slot_fresh[$past(chan_ff)])
        else $error("converted value not stored in its result register");

    a_restart_first: assert property (@(posedge CLK) disable iff (RESET)
        (state_ff == ST_IDLE) && TRIG && enable_ff && !first_en[3]
        |=> chan_ff == $past(first_en[CHAN_W-1:0]))
        else $error("sequence did not begin at the first enabled channel");

    a_enable_reset: assert property (@(posedge CLK)
        $past(RESET) && !RESET |-> (res_en_ff == RES_EN_RESET) && !enable_ff)
        else $error("result enables not zero after reset");

    a_step_ascending: assert property (@(posedge CLK) disable iff (RESET)
        (state_ff == ST_WAIT) && CONV_DONE && enable_ff && !next_en[3]
        |=> (chan_ff > $past(chan_ff)) && res_en_ff.en[chan_ff] && CONV_START)
        else $error("next channel not the next enabled one above");

    a_mode_readback: assert property (@(posedge CLK) disable iff (RESET)
        RD && sel_mode
        |=> (RDATA[MODE_DONE_BIT] == $past(done_ff)) && (RDATA[MODE_EN_BIT] == $past(enable_ff))
            && (RDATA[6:1] == 6'h00))
        else $error("mode register readback wrong");

    a_res_en_readback: assert property (@(posedge CLK) disable iff (RESET)
        RD && sel_res_en
        |=> RDATA == {16'h0000, $past(res_en_ff)})
        else $error("result enable readback wrong");

    a_chan_held: assert property (@(posedge CLK) disable iff (RESET)
        (state_ff == ST_WAIT) && !CONV_DONE
        |=> (state_ff == ST_WAIT) && $stable(chan_ff))
        else $error("channel changed before its conversion finished");

    a_idle_no_start: assert property (@(posedge CLK) disable iff (RESET)
        (state_ff == ST_IDLE) && !(TRIG && enable_ff && !first_en[3])
        |=> (state_ff == ST_IDLE) && !CONV_START)
        else $error("conversion started without trigger or enabled result");

    a_start_single: assert property (@(posedge CLK) disable iff (RESET)
        CONV_START |=> !CONV_START)
        else $error("conversion start longer than one cycle");

    a_done_sticky: assert property (@(posedge CLK) disable iff (RESET)
        stat_ff[IRQ_DONE_BIT] && !(WR && sel_stat && WDATA[IRQ_DONE_BIT])
        |=> stat_ff[IRQ_DONE_BIT])
        else $error("sequence done status lost without a clear");

endmodule // apsrc_ctrl

// File: dv/tb_apsrc_ctrl.sv
module tb_apsrc_ctrl
    import apsrc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [31:0] addr = 32'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic trg = 1'b0;
    logic conv_done = 1'b0;
    logic [CONV_DATA_W-1:0] conv_data = '0;
    logic [31:0] rdata;
    logic conv_start;
    logic [CHAN_W-1:0] conv_chan;
    logic irq;
    logic rd_q = 1'b0;
    int fail_count = 0;
    int compares = 0;
    int seed = 6;
    int slow = 0;
    int d;
    logic [CONV_DATA_W-1:0] v;
    logic [31:0] rq[$];
    logic [CHAN_W-1:0] cq[$];
    logic [CONV_DATA_W-1:0] val[NUM_RESULTS];

    always #20 clk = ~clk;

    apsrc_ctrl dut_u (
        .CLK(clk),
        .RESET(reset),
        .ADDR(addr),
        .WDATA(wdata),
        .WR(wr),
        .RD(rd),
        .RDATA(rdata),
        .TRIG(trg),
        .CONV_START(conv_start),
        .CONV_CHAN(conv_chan),
        .CONV_DONE(conv_done),
        .CONV_DATA(conv_data),
        .IRQ(irq)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        $display("Compares %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic wreg(input logic [31:0] a, input logic [31:0] dt);
        addr <= a;
        wdata <= dt;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rreg(input logic [31:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rres(input int i, input logic fr);
        rreg(ADDR_RESULT_BASE + 32'(4 * i), {16'h0, fr, 5'h0, val[i]});
    endtask

    task automatic trig();
        trg <= 1'b1;
        @(posedge clk);
        trg <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 400) begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, irq}, 32'h1);
    endtask

    // Read data notes checked the cycle after the strobe
    always @(posedge clk) rd_q <= rd;
    always @(negedge clk) begin
        if (rd_q) begin
            chk(rdata, rq.size() ? rq.pop_front() : 'x);
        end
    end

    // Converter stand-in; every start must match a noted channel
    always begin
        @(negedge clk);
        if (conv_start === 1'b1) begin
            chk({29'h0, conv_chan}, cq.size() ? {29'h0, cq.pop_front()} : 'x);
            d = slow ? slow : 1 + ($random(seed) & 3);
            repeat (d) @(posedge clk);
            v = CONV_DATA_W'($random(seed));
            val[conv_chan] = v;
            conv_data <= v;
            conv_done <= 1'b1;
            @(posedge clk);
            conv_done <= 1'b0;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        wrap_up();
    end

    initial begin
        logic [7:0] m;
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        rreg(ADDR_MODE_CTRL, 32'h0);
        rreg(ADDR_RES_EN, 32'h0);
        rreg(ADDR_IRQ_STAT, 32'h0);
        rreg(ADDR_IRQ_MASK, 32'h0);
        rreg(32'hffffcd68, 32'h0);
        wreg(ADDR_IRQ_MASK, 32'h7);
        wreg(ADDR_MODE_CTRL, 32'h81);
        rreg(ADDR_MODE_CTRL, 32'h1);
        trig();
        wreg(ADDR_RES_EN, 32'h5);
        rreg(ADDR_RES_EN, 32'h5);
        cq.push_back(3'h0);
        cq.push_back(3'h2);
        trig();
        rreg(ADDR_MODE_CTRL, 32'h81);
        wait_irq();
        rreg(ADDR_MODE_CTRL, 32'h1);
        rreg(ADDR_IRQ_STAT, 32'h1);
        rres(0, 1'b1);
        rres(2, 1'b1);
        rres(0, 1'b0);
        rreg(ADDR_RESULT_BASE + 32'h4, 32'h0);
        wreg(ADDR_IRQ_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        // Drop enable while channel 0 is converting
        slow = 6;
        wreg(ADDR_RES_EN, 32'hff);
        cq.push_back(3'h0);
        trig();
        wreg(ADDR_MODE_CTRL, 32'h0);
        wait_irq();
        rreg(ADDR_MODE_CTRL, 32'h0);
        rreg(ADDR_IRQ_STAT, 32'h2);
        rres(0, 1'b1);
        wreg(ADDR_IRQ_STAT, 32'h2);
        slow = 0;
        wreg(ADDR_MODE_CTRL, 32'h1);
        for (int i = 0; i < NUM_RESULTS; i++) cq.push_back(i[CHAN_W-1:0]);
        trig();
        wait_irq();
        rreg(ADDR_IRQ_STAT, 32'h1);
        rres(7, 1'b1);
        wreg(ADDR_IRQ_STAT, 32'h1);
        repeat (4) begin
            m = 8'($random(seed));
            m = m | 8'h08;
            wreg(ADDR_RES_EN, {24'h0, m});
            for (int i = 0; i < NUM_RESULTS; i++) if (m[i]) cq.push_back(i[CHAN_W-1:0]);
            trig();
            wait_irq();
            rreg(ADDR_MODE_CTRL, 32'h1);
            wreg(ADDR_IRQ_STAT, 32'h1);
        end
        // Second trigger while busy, overrun masked
        slow = 6;
        wreg(ADDR_IRQ_MASK, 32'h3);
        wreg(ADDR_RES_EN, 32'h80);
        cq.push_back(3'h7);
        trig();
        trig();
        wait_irq();
        rreg(ADDR_IRQ_STAT, 32'h5);
        wreg(ADDR_IRQ_STAT, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wreg(ADDR_IRQ_MASK, 32'h7);
        chk({31'h0, irq}, 32'h1);
        wreg(ADDR_IRQ_STAT, 32'h4);
        chk({31'h0, irq}, 32'h0);
        repeat (4) @(posedge clk);
        chk(32'(cq.size()), 32'h0);
        wrap_up();
    end
endmodule // tb_apsrc_ctrl
